// File: design/rtcsa_pkg.sv
// Constants and state codes for the serial access front-end
`default_nettype none
package rtcsa_pkg;
	// ----------------------------------------------------------------
	// Bus addressing
	// ----------------------------------------------------------------
	localparam logic [7:0] RTCSA_SLAVE_ADDR = 8'hd0; // Fixed slave byte, direction bit zero
	localparam int RTCSA_MEM_DEPTH = 64; // Clock registers then general RAM
	localparam int RTCSA_PTR_W = 6;
	localparam logic [5:0] RTCSA_PTR_RESET = 6'h00; // Seconds register
	localparam logic [5:0] RTCSA_PTR_STEP = 6'h01;
	localparam logic [3:0] RTCSA_BYTE_BITS = 4'h8;
	localparam logic [3:0] RTCSA_CNT_ZERO = 4'h0;
	localparam logic [3:0] RTCSA_CNT_STEP = 4'h1;

	// ----------------------------------------------------------------
	// Serial protocol states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		RTCSA_IDLE = 4'h0,
		RTCSA_DEV_ADDR = 4'h1,
		RTCSA_ACK_DEV = 4'h2,
		RTCSA_WORD_ADDR = 4'h3,
		RTCSA_ACK_WORD = 4'h4,
		RTCSA_WR_DATA = 4'h5,
		RTCSA_ACK_WR = 4'h6,
		RTCSA_RD_DATA = 4'h7,
		RTCSA_MST_ACK = 4'h8
	} rtcsa_state_e;
endpackage : rtcsa_pkg
`default_nettype wire

// File: design/rtcsa_top.sv
// Two-wire slave access with power-fail lockout for a clock/calendar RAM
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Answer only start plus slave byte D0h or D1h
// - 64 bytes: clock registers then RAM
// - Supply low aborts access in progress
// - Supply low clears address pointer
// - Supply low ignores bus, no writes
// - Supply back resumes accepting bus inputs
// - Pointer advances after each written data byte
// - Read pointer advances only on master ack
// - Write direction loads word address first
// - Bare read starts at current pointer
module rtcsa_top import rtcsa_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Two-wire bus
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Supply monitor, high while above switchover_threshold
	input wire logic supply_ok
);

	// ----------------------------------------------------------------
	// Storage and state
	// ----------------------------------------------------------------
	logic [7:0] mem [RTCSA_MEM_DEPTH];
	rtcsa_state_e state_reg, state_next;
	logic [5:0] ptr_reg, ptr_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] shift_reg, shift_next;
	logic oe_reg, oe_next;
	logic scl_prev_reg, sda_prev_reg;
	logic mack_reg, mack_next;

	// ----------------------------------------------------------------
	// Bus event decode
	// ----------------------------------------------------------------
	wire logic scl_rise = scl_in & ~scl_prev_reg;
	wire logic scl_fall = ~scl_in & scl_prev_reg;
	wire logic start_cond = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
	wire logic stop_cond = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;
	wire logic byte_full = (cnt_reg == RTCSA_BYTE_BITS);
	wire logic addr_match = (shift_reg[7:1] == RTCSA_SLAVE_ADDR[7:1]);
	wire logic [5:0] ptr_inc = ptr_reg + RTCSA_PTR_STEP;
	wire logic [7:0] rd_byte = mem[ptr_reg];
	wire logic [7:0] rd_byte_inc = mem[ptr_inc];
	wire logic mem_wr = supply_ok & scl_fall & (state_reg == RTCSA_WR_DATA) & byte_full;

	// Next-state logic of the serial engine
	always_comb begin
		state_next = state_reg;
		ptr_next = ptr_reg;
		cnt_next = cnt_reg;
		shift_next = shift_reg;
		oe_next = oe_reg;
		mack_next = mack_reg;
		if (!supply_ok) begin
			state_next = RTCSA_IDLE;
			ptr_next = RTCSA_PTR_RESET;
			oe_next = 1'b0;
		end else if (start_cond) begin
			state_next = RTCSA_DEV_ADDR;
			cnt_next = RTCSA_CNT_ZERO;
			oe_next = 1'b0;
		end else if (stop_cond) begin
			state_next = RTCSA_IDLE;
			oe_next = 1'b0;
		end else if (scl_rise) begin
			unique case (state_reg)
				RTCSA_DEV_ADDR, RTCSA_WORD_ADDR, RTCSA_WR_DATA: begin
					shift_next = {shift_reg[6:0], sda_in};
					cnt_next = cnt_reg + RTCSA_CNT_STEP;
				end
				RTCSA_RD_DATA: cnt_next = cnt_reg + RTCSA_CNT_STEP;
				RTCSA_MST_ACK: mack_next = ~sda_in;
				default: ;
			endcase
		end else if (scl_fall) begin
			unique case (state_reg)
				RTCSA_DEV_ADDR: if (byte_full) begin
					state_next = addr_match ? RTCSA_ACK_DEV : RTCSA_IDLE;
					oe_next = addr_match;
				end
				RTCSA_ACK_DEV: begin
					cnt_next = RTCSA_CNT_ZERO;
					if (shift_reg[0]) begin
						state_next = RTCSA_RD_DATA;
						shift_next = rd_byte;
						oe_next = ~rd_byte[7];
					end else begin
						state_next = RTCSA_WORD_ADDR;
						oe_next = 1'b0;
					end
				end
				RTCSA_WORD_ADDR: if (byte_full) begin
					ptr_next = shift_reg[5:0];
					state_next = RTCSA_ACK_WORD;
					oe_next = 1'b1;
				end
				RTCSA_WR_DATA: if (byte_full) begin
					ptr_next = ptr_inc;
					state_next = RTCSA_ACK_WR;
					oe_next = 1'b1;
				end
				RTCSA_ACK_WORD, RTCSA_ACK_WR: begin
					state_next = RTCSA_WR_DATA;
					cnt_next = RTCSA_CNT_ZERO;
					oe_next = 1'b0;
				end
				RTCSA_RD_DATA: begin
					if (byte_full) begin
						state_next = RTCSA_MST_ACK;
						oe_next = 1'b0;
					end else begin
						shift_next = {shift_reg[6:0], 1'b0};
						oe_next = ~shift_reg[6];
					end
				end
				RTCSA_MST_ACK: begin
					cnt_next = RTCSA_CNT_ZERO;
					if (mack_reg) begin
						ptr_next = ptr_inc;
						state_next = RTCSA_RD_DATA;
						shift_next = rd_byte_inc;
						oe_next = ~rd_byte_inc[7];
					end else begin
						state_next = RTCSA_IDLE; // Leave line high after nack
					end
				end
				default: ;
			endcase
		end
	end

	// Engine registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= RTCSA_IDLE;
			ptr_reg <= RTCSA_PTR_RESET;
			cnt_reg <= RTCSA_CNT_ZERO;
			shift_reg <= 8'h00;
			oe_reg <= 1'b0;
			mack_reg <= 1'b0;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			state_reg <= state_next;
			ptr_reg <= ptr_next;
			cnt_reg <= cnt_next;
			shift_reg <= shift_next;
			oe_reg <= oe_next;
			mack_reg <= mack_next;
			scl_prev_reg <= scl_in;
			sda_prev_reg <= sda_in;
			sda_out <= 1'b0;
			sda_oe <= oe_next;
		end
	end

	// Byte store, written only with good supply
	always_ff @(posedge clk) begin
		if (mem_wr) begin
			mem[ptr_reg] <= shift_reg;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	addr_reject_a: assert property (@(posedge clk) disable iff (!reset_n)
		(supply_ok && !start_cond && !stop_cond && scl_fall && state_reg == RTCSA_DEV_ADDR && byte_full
		&& !addr_match) |=> (state_reg == RTCSA_IDLE) && !sda_oe)
		else $error("foreign slave byte was not ignored");
	addr_accept_a: assert property (@(posedge clk) disable iff (!reset_n)
		(supply_ok && !start_cond && !stop_cond && scl_fall && state_reg == RTCSA_DEV_ADDR && byte_full
		&& addr_match) |=> (state_reg == RTCSA_ACK_DEV) && sda_oe)
		else $error("own slave byte not acknowledged");
	abort_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(supply_ok) |=> state_reg == RTCSA_IDLE)
		else $error("access not aborted on supply drop");
	ptr_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
		!supply_ok |=> ptr_reg == RTCSA_PTR_RESET)
		else $error("pointer not cleared on supply drop");
	bus_ignored_a: assert property (@(posedge clk) disable iff (!reset_n)
		!supply_ok [*2] |-> !sda_oe && !mem_wr && state_reg == RTCSA_IDLE)
		else $error("bus activity during low supply");
	resume_start_a: assert property (@(posedge clk) disable iff (!reset_n)
		(supply_ok && $past(supply_ok) && start_cond) |=> state_reg == RTCSA_DEV_ADDR)
		else $error("start not recognised after recovery");
	wr_advance_a: assert property (@(posedge clk) disable iff (!reset_n)
		mem_wr && !start_cond && !stop_cond |=> ptr_reg == $past(ptr_reg) + RTCSA_PTR_STEP)
		else $error("pointer did not advance after write byte");
	nack_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		(supply_ok && !start_cond && !stop_cond && scl_fall && state_reg == RTCSA_MST_ACK && !mack_reg)
		|=> $stable(ptr_reg) && state_reg == RTCSA_IDLE)
		else $error("pointer moved without master ack");
	word_load_a: assert property (@(posedge clk) disable iff (!reset_n)
		(supply_ok && !start_cond && !stop_cond && scl_fall && state_reg == RTCSA_WORD_ADDR && byte_full)
		|=> ptr_reg == $past(shift_reg[5:0]))
		else $error("word address not loaded");
	ack_release_a: assert property (@(posedge clk) disable iff (!reset_n)
		(supply_ok && !start_cond && !stop_cond && scl_fall && state_reg == RTCSA_ACK_WORD)
		|=> state_reg == RTCSA_WR_DATA && !sda_oe)
		else $error("line not released after word address ack");
	rd_advance_a: assert property (@(posedge clk) disable iff (!reset_n)
		(supply_ok && !start_cond && !stop_cond && scl_fall && state_reg == RTCSA_MST_ACK && mack_reg)
		|=> ptr_reg == $past(ptr_reg) + RTCSA_PTR_STEP && state_reg == RTCSA_RD_DATA)
		else $error("pointer did not advance on master ack");
	bare_read_a: assert property (@(posedge clk) disable iff (!reset_n)
		(supply_ok && !start_cond && !stop_cond && scl_fall && state_reg == RTCSA_ACK_DEV && shift_reg[0])
		|=> $stable(ptr_reg) && state_reg == RTCSA_RD_DATA)
		else $error("read did not start at held pointer");
	drain_only_a: assert property (@(posedge clk) disable iff (!reset_n)
		sda_out == 1'b0)
		else $error("data line driven high");

endmodule : rtcsa_top
`default_nettype wire

// File: test/rtcsa_master.sv
// Two-wire bus master model for the serial access block
`timescale 1ns/1ps
`default_nettype none
module rtcsa_master (
	// Bus, sda_m high releases data
	output logic scl = 1'b1,
	output logic sda_m = 1'b1,
	input wire logic sda
);
	// One bus step of four quarters, each four clocks long
	task automatic step(input logic b, input logic mid, input logic sc, output logic s);
		sda_m = b;
		#40;
		scl = 1'b1;
		#40;
		s = sda;
		sda_m = mid;
		#40;
		scl = sc;
		#40;
	endtask : step
	// Byte plus ninth bit, most significant first
	task automatic xfer(input logic [8:0] d, output logic [8:0] s);
		for (int i = 8; i >= 0; i--) begin
			step(d[i], d[i], 1'b0, s[i]);
		end
	endtask : xfer
endmodule : rtcsa_master
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the serial access block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0, reset_n = 1'b0, supply_ok = 1'b1;
	logic scl, sda_m, sda_out, sda_oe;
	logic [8:0] r;
	int mismatches = 0, tests_run = 0;
	logic [7:0] rows [4][2] = '{'{8'h01, 8'h5a}, '{8'h05, 8'ha5}, '{8'h08, 8'h3c}, '{8'h3e, 8'hc3}};
	wire logic sda = sda_m & ~sda_oe; // Pulled-up wire
	rtcsa_top DUT (.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .supply_ok(supply_ok));
	rtcsa_master bus (.scl(scl), .sda_m(sda_m), .sda(sda));
	// Clock and hang guard
	always #5 clk = ~clk;
	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		wrap_up();
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up;
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	task automatic put(input logic [7:0] d, input logic ak);
		bus.xfer({d, 1'b1}, r);
		check({7'h00, r[0]}, {7'h00, ak});
	endtask : put
	task automatic get(input logic mk, input logic [7:0] exp);
		bus.xfer({8'hff, mk}, r);
		check(r[8:1], exp);
	endtask : get
	task automatic head(input logic [7:0] wa);
		bus.step(1'b1, 1'b0, 1'b0, r[0]);
		put(8'hd0, 1'b0);
		put(wa, 1'b0);
	endtask : head
	initial begin
		repeat (6) @(posedge clk);
		#1 reset_n = 1'b1;
		check({6'h00, sda_out, sda_oe}, 8'h00);
		// Write each row, read it back by combined read
		foreach (rows[i]) begin
			head(rows[i][0]);
			put(rows[i][1], 1'b0);
			head(rows[i][0]);
			bus.step(1'b1, 1'b0, 1'b0, r[0]);
			put(8'hd1, 1'b0);
			get(1'b1, rows[i][1]);
			bus.step(1'b0, 1'b1, 1'b1, r[0]);
		end
		// Burst past the top wraps to seconds
		head(8'h3f);
		put(8'h22, 1'b0);
		put(8'h33, 1'b0);
		head(8'h3f);
		bus.step(1'b1, 1'b0, 1'b0, r[0]);
		put(8'hd1, 1'b0);
		get(1'b0, 8'h22);
		get(1'b1, 8'h33);
		// Nack holds pointer for a bare read, wrong slave byte ignored
		bus.step(1'b1, 1'b0, 1'b0, r[0]);
		put(8'hd1, 1'b0);
		get(1'b1, 8'h33);
		bus.step(1'b1, 1'b0, 1'b0, r[0]);
		put(8'ha0, 1'b1);
		// Supply drop in mid write, then recovery
		head(8'h05);
		supply_ok = 1'b0;
		put(8'hee, 1'b1);
		check({7'h00, sda_oe}, 8'h00);
		bus.step(1'b0, 1'b1, 1'b1, r[0]);
		supply_ok = 1'b1;
		bus.step(1'b1, 1'b0, 1'b0, r[0]);
		put(8'hd1, 1'b0);
		get(1'b1, 8'h33);
		bus.step(1'b0, 1'b1, 1'b1, r[0]);
		// Byte under the cut write kept its old value
		head(8'h05);
		bus.step(1'b1, 1'b0, 1'b0, r[0]);
		put(8'hd1, 1'b0);
		get(1'b1, 8'ha5);
		// Reset in mid-run releases the line and clears the pointer
		reset_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 check({6'h00, sda_out, sda_oe}, 8'h00);
		reset_n = 1'b1;
		bus.step(1'b1, 1'b0, 1'b0, r[0]);
		put(8'hd1, 1'b0);
		check({7'h00, sda_oe}, 8'h01);
		// Supply drop while the device drives a read bit
		supply_ok = 1'b0;
		repeat (2) @(posedge clk);
		#1 check({7'h00, sda_oe}, 8'h00);
		get(1'b1, 8'hff);
		supply_ok = 1'b1;
		bus.step(1'b0, 1'b1, 1'b1, r[0]);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
